// ---- rtl/phsg_host_bus_glue.v ----
// host-bus glue: target, master arbiter, power management, card mode
// Overview of operation
// - Target logic answers every slave access that selects this device.
// - While packets move in D0, the device requests the host bus and masters it for the engine.
// - A configuration power register lets software choose D0, D1, D2 or D3hot.
// - A wake event can be raised from D0, D1, D2, D3hot and D3cold.
// - Without auxiliary power, wake events from D3cold are blocked.
// - A low card-mode strap enables card operation with its extra configuration space.
// - In card mode the card information structure is loaded from serial memory.
// - In card mode wake events drive the card status change output.
// - An arbiter picks which data engine reaches the host bus core.
// - Slave accesses are decoded and read data comes from the owning unit.
// - Unit interrupts are merged into the host interrupt request while in D0.
// - The isochronous unit serves its registers and keeps its interrupt status.
// - The asynchronous unit serves its registers and keeps its interrupt status.
`timescale 1ns/100ps
`default_nettype none
`include "phsg_defines.vh"
module phsg_host_bus_glue #(
  parameter NENG = 2,
  parameter NEV  = 8
) (
  input  wire            ref_clk,
  input  wire            rstn,
  input  wire            clkEn,
  input  wire            card_mode_select_n,
  input  wire            auxPower,
  input  wire            d3Cold,
  input  wire            wakeEvent,
  input  wire            cfgSel,
  input  wire            cfgWr,
  input  wire [7:0]      cfgAddr,
  input  wire [31:0]     cfgWdata,
  output reg  [31:0]     cfgRdata,
  output reg             cfgAck,
  input  wire            memSel,
  input  wire            memWr,
  input  wire [11:0]     memAddr,
  input  wire [31:0]     memWdata,
  output reg  [31:0]     memRdata,
  output reg             memAck,
  input  wire [NENG-1:0] engReq,
  input  wire            masterDone,
  input  wire            busGnt,
  output reg  [NENG-1:0] engGnt,
  output reg             busReq,
  input  wire            romValid,
  input  wire [4:0]      romAddr,
  input  wire [31:0]     romData,
  input  wire [NEV-1:0]  isoEvents,
  input  wire [NEV-1:0]  asyncEvents,
  output reg             intReq,
  output reg             pmeReq,
  output reg             card_status_change,
  output reg  [1:0]      powerState,
  output reg             cardMode
);
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  reg [1:0] cardSync;
  reg [1:0] auxSync;
  reg [1:0] coldSync;
  reg [1:0] wakeSync;
  // first stages feed only the second stages
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cardSync <= 2'h3;
      auxSync  <= 2'h0;
      coldSync <= 2'h0;
      wakeSync <= 2'h0;
    end
    else if (clkEn)
    begin
      cardSync <= {cardSync[0], card_mode_select_n};
      auxSync  <= {auxSync[0], auxPower};
      coldSync <= {coldSync[0], d3Cold};
      wakeSync <= {wakeSync[0], wakeEvent};
    end
  end
  wire cardModeNow = ~cardSync[1];
  wire auxOk       = auxSync[1];
  wire inCold      = coldSync[1];
  wire wakeNow     = wakeSync[1];

  // ---------------------------------------------
  // configuration target: power and card space
  // ---------------------------------------------
  reg        pmeEn;
  reg        pmeSts;
  reg [31:0] cisTable [0:31];
  reg [1:0]  strapAge;
  wire       pmcsrHit = cfgSel && (cfgAddr == `PHSG_CFG_PMCSR);
  wire       pmeClr   = pmcsrHit && cfgWr && cfgWdata[`PHSG_PM_STS_BIT];
  wire       coldBlock = inCold && !auxOk;
  wire       pmeSet    = wakeNow && pmeEn && !coldBlock;
  wire       tupleHit  = cardMode && (cfgAddr >= `PHSG_CFG_TUPLE);
  integer    i;

  // strap caught once, third edge on: before that the sync stage shows its reset level
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strapAge <= 2'h0;
      cardMode <= 1'b0;
    end
    else if (clkEn && strapAge != 2'h3)
    begin
      strapAge <= strapAge + 2'h1;
      cardMode <= (strapAge == 2'h2) ? cardModeNow : cardMode;
    end
  end

  // card information structure loaded from serial memory
  always @(posedge ref_clk)
  begin
    if (clkEn && cardMode && romValid)
      cisTable[romAddr] <= romData;
  end

  // power register and config read data
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      powerState <= `PHSG_D0;
      pmeEn      <= 1'b0;
      pmeSts     <= 1'b0;
      cfgRdata   <= 32'h00000000;
      cfgAck     <= 1'b0;
      pmeReq     <= 1'b0;
      card_status_change <= 1'b0;
    end
    else if (clkEn)
    begin
      if (pmcsrHit && cfgWr)
      begin
        powerState <= cfgWdata[`PHSG_PM_STATE_LO+1:`PHSG_PM_STATE_LO];
        pmeEn      <= cfgWdata[`PHSG_PM_EN_BIT];
      end
      // set beats a same-cycle clear
      if (pmeSet)
        pmeSts <= 1'b1;
      else if (pmeClr)
        pmeSts <= 1'b0;
      pmeReq <= (pmeSts || pmeSet) && !cardMode;
      card_status_change <= (pmeSts || pmeSet) && cardMode;
      cfgAck   <= cfgSel;
      cfgRdata <= 32'h00000000;
      if (pmcsrHit)
      begin
        cfgRdata[1:0] <= powerState;
        cfgRdata[`PHSG_PM_EN_BIT]  <= pmeEn;
        cfgRdata[`PHSG_PM_STS_BIT] <= pmeSts;
      end
      else if (cardMode && cfgAddr == `PHSG_CFG_CIS)
        cfgRdata <= {24'h000000, `PHSG_CFG_TUPLE};
      else if (cardMode && cfgAddr == `PHSG_CFG_BAR1)
        cfgRdata <= 32'h00000000;
      else if (tupleHit)
        cfgRdata <= cisTable[cfgAddr[6:2]];
    end
  end

  // ---------------------------------------------
  // register select and interrupt merge
  // ---------------------------------------------
  wire        selAsync = memAddr[`PHSG_SEL_BIT];
  wire [31:0] isoData;
  wire [31:0] asyncData;
  wire        isoIrq;
  wire        asyncIrq;
  reg         memPend;
  reg         pendAsync;

  phsg_reg_unit #(.NEV(NEV)) isoUnit (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .sel     (memSel && !selAsync),
    .wr      (memWr),
    .addr    (memAddr[5:2]),
    .wdata   (memWdata),
    .events  (isoEvents),
    .rdata   (isoData),
    .irq     (isoIrq)
  );

  phsg_reg_unit #(.NEV(NEV)) asyncUnit (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .sel     (memSel && selAsync),
    .wr      (memWr),
    .addr    (memAddr[5:2]),
    .wdata   (memWdata),
    .events  (asyncEvents),
    .rdata   (asyncData),
    .irq     (asyncIrq)
  );

  // unit answers one cycle later, so select is pipelined
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memPend   <= 1'b0;
      pendAsync <= 1'b0;
      memAck    <= 1'b0;
      memRdata  <= 32'h00000000;
      intReq    <= 1'b0;
    end
    else if (clkEn)
    begin
      memPend   <= memSel;
      pendAsync <= selAsync;
      memAck    <= memPend;
      memRdata  <= memPend ? (pendAsync ? asyncData : isoData) : 32'h00000000;
      // merge unit interrupts; held off below D0
      intReq    <= (isoIrq || asyncIrq) && (powerState == `PHSG_D0);
    end
  end

  // ---------------------------------------------
  // engine arbiter and bus master request
  // ---------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_REQ  = 3'b010;
  localparam ST_OWN  = 3'b100;
  reg [2:0]      state;
  reg [2:0]      next_state;
  reg [NENG-1:0] pick;
  reg [NENG-1:0] lastGnt;

  // lowest request not granted last time wins, for fairness
  always @*
  begin
    pick = {NENG{1'b0}};
    for (i = NENG - 1; i >= 0; i = i - 1)
      if (engReq[i] && !(lastGnt[i] && (engReq & ~lastGnt) != {NENG{1'b0}}))
        pick = {NENG{1'b0}} | ({{(NENG-1){1'b0}}, 1'b1} << i);
  end

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (engReq != {NENG{1'b0}} && powerState == `PHSG_D0)
                 next_state = ST_REQ;
      ST_REQ:  if (busGnt)
                 next_state = ST_OWN;
      ST_OWN:  if (masterDone)
                 next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state   <= ST_IDLE;
      engGnt  <= {NENG{1'b0}};
      lastGnt <= {NENG{1'b0}};
      busReq  <= 1'b0;
    end
    else if (clkEn)
    begin
      state <= next_state;
      if (state == ST_IDLE && next_state == ST_REQ)
      begin
        engGnt  <= pick;
        lastGnt <= pick;
      end
      else if (state == ST_OWN && masterDone)
        engGnt <= {NENG{1'b0}};
      busReq <= (next_state == ST_REQ) || (next_state == ST_OWN);
    end
  end
endmodule
`default_nettype wire

// ---- rtl/phsg_defines.vh ----
// constants for the host-bus glue block
`ifndef PHSG_DEFINES_VH
`define PHSG_DEFINES_VH
// power states (two-bit state field)
`define PHSG_D0          2'h0
`define PHSG_D1          2'h1
`define PHSG_D2          2'h2
`define PHSG_D3HOT       2'h3
// configuration-space offsets (byte addresses)
`define PHSG_CFG_PMCSR   8'h44
`define PHSG_CFG_CIS     8'h28
`define PHSG_CFG_BAR1    8'h14
`define PHSG_CFG_TUPLE   8'h80
`define PHSG_TUPLE_BYTES 8'h80
// pmcsr field positions
`define PHSG_PM_STATE_LO 0
`define PHSG_PM_EN_BIT   8
`define PHSG_PM_STS_BIT  15
// slave register select: address bit that picks async over iso
`define PHSG_SEL_BIT     11
// reset value of the pmcsr
`define PHSG_PMCSR_RST   32'h00000000
`endif

// ---- rtl/phsg_reg_unit.v ----
// register-access unit: slave registers plus sticky interrupt status
`timescale 1ns/100ps
`default_nettype none
module phsg_reg_unit #(
  parameter NEV = 8
) (
  input  wire           ref_clk,
  input  wire           rstn,
  input  wire           clkEn,
  input  wire           sel,
  input  wire           wr,
  input  wire [3:0]     addr,
  input  wire [31:0]    wdata,
  input  wire [NEV-1:0] events,
  output reg  [31:0]    rdata,
  output reg            irq
);
  reg [NEV-1:0] status;
  reg [NEV-1:0] mask;
  wire          hitSts  = sel && (addr == 4'h0);
  wire          hitMask = sel && (addr == 4'h1);
  wire [NEV-1:0] clrBits = (hitSts && wr) ? wdata[NEV-1:0] : {NEV{1'b0}};

  // ---------------------------------------------
  // status, mask, read mux
  // ---------------------------------------------
  // set wins over clear so no event is lost
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status <= {NEV{1'b0}};
      mask   <= {NEV{1'b0}};
      rdata  <= 32'h00000000;
      irq    <= 1'b0;
    end
    else if (clkEn)
    begin
      status <= (status & ~clrBits) | events;
      if (hitMask && wr)
        mask <= wdata[NEV-1:0];
      rdata <= 32'h00000000;
      if (hitSts)
        rdata[NEV-1:0] <= status;
      else if (hitMask)
        rdata[NEV-1:0] <= mask;
      irq <= |(status & mask);
    end
  end
endmodule
`default_nettype wire

// ---- tb/phsg_assertions.sv ----
// port checker for the host-bus glue block
`timescale 1ns/100ps
`default_nettype none
`include "phsg_defines.vh"
module phsg_assertions #(
  parameter NENG = 2
) (
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            cfgSel,
  input wire logic            cfgWr,
  input wire logic [7:0]      cfgAddr,
  input wire logic [31:0]     cfgWdata,
  input wire logic            cfgAck,
  input wire logic            memSel,
  input wire logic            memAck,
  input wire logic            masterDone,
  input wire logic            busGnt,
  input wire logic [NENG-1:0] engGnt,
  input wire logic            busReq,
  input wire logic            intReq,
  input wire logic            pmeReq,
  input wire logic            card_status_change,
  input wire logic [1:0]      powerState,
  input wire logic            cardMode
);
  // ----------------------------------------
  // properties, all on the host clock
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  a_cfg_ack_lat: assert property (cfgSel |=> cfgAck)
    else $error("config ack missing");
  a_ack_cause: assert property (cfgAck |-> $past(cfgSel))
    else $error("config ack without access");
  a_mem_ack_lat: assert property (memSel |-> ##2 memAck)
    else $error("slave ack missing");
  a_pstate_write: assert property (cfgSel && cfgWr && cfgAddr == `PHSG_CFG_PMCSR
    |=> powerState == $past(cfgWdata[1:0])) else $error("power state not taken");
  a_gnt_onehot: assert property ($onehot0(engGnt))
    else $error("two engines granted");
  a_req_with_gnt: assert property (busReq == (|engGnt))
    else $error("bus request and grant disagree");
  a_gnt_held: assert property (|engGnt && !masterDone |=> $stable(engGnt))
    else $error("grant moved mid transfer");
  a_done_release: assert property (busReq && busGnt && $past(busGnt) && masterDone
    |=> !busReq) else $error("bus kept after transfer end");
  a_int_gated: assert property ((powerState != `PHSG_D0)[*3] |-> !intReq)
    else $error("interrupt outside full power");
  a_mode_split: assert property (cardMode ? !pmeReq : !card_status_change)
    else $error("wake on wrong pin");
  cover property (busReq && masterDone);
  cover property (intReq);
  cover property (pmeReq);
  cover property (card_status_change);
endmodule
bind phsg_host_bus_glue phsg_assertions #(.NENG(NENG)) u_chk (.ref_clk, .rstn, .cfgSel,
  .cfgWr, .cfgAddr, .cfgWdata, .cfgAck, .memSel, .memAck, .masterDone, .busGnt, .engGnt,
  .busReq, .intReq, .pmeReq, .card_status_change, .powerState, .cardMode);
`default_nettype wire

// ---- tb/phsg_host_model.sv ----
// host-bridge model: grants the bus and ends master transfers
`timescale 1ns/100ps
`default_nettype none
module phsg_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       busReq,
  input  wire logic [2:0] lag,
  output var logic        busGnt,
  output var logic        masterDone
);
  logic [4:0] cnt;
  // grant after lag cycles; the transfer runs lag+2 more so done never precedes grant
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn || !busReq)
    begin
      {busGnt, masterDone, cnt} <= 0;
    end
    else
    begin
      cnt <= cnt + 5'h1;
      busGnt <= busGnt || cnt == {2'h0, lag};
      masterDone <= cnt == {1'b0, lag, 1'b0} + 5'h2;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the host-bus glue block
`timescale 1ns/100ps
`default_nettype none
`include "phsg_defines.vh"
module tb;
  logic        ref_clk = 0, rstn = 0, clkEn = 1, card_mode_select_n = 1, auxPower = 0;
  logic        d3Cold = 0, wakeEvent = 0, cfgSel = 0, cfgWr = 0, memSel = 0, memWr = 0;
  logic        romValid = 0, cfgAck, memAck, busReq, busGnt, masterDone, intReq, pmeReq;
  logic        card_status_change, cardMode;
  logic [1:0]  engReq = 0, engGnt, powerState, prev;
  logic [2:0]  lag = 0;
  logic [4:0]  romAddr = 0;
  logic [7:0]  cfgAddr = 0, isoEvents = 0, asyncEvents = 0, ev;
  logic [11:0] memAddr = 0;
  logic [31:0] cfgWdata = 0, memWdata = 0, romData = 0, cfgRdata, memRdata, rd, v, seed = 34;
  int          error_cnt = 0, checks_done = 0;

  // free-running host clock
  always #10 ref_clk = ~ref_clk;

  phsg_host_bus_glue dut (.ref_clk, .rstn, .clkEn, .card_mode_select_n, .auxPower, .d3Cold,
    .wakeEvent, .cfgSel, .cfgWr, .cfgAddr, .cfgWdata, .cfgRdata, .cfgAck, .memSel, .memWr,
    .memAddr, .memWdata, .memRdata, .memAck, .engReq, .masterDone, .busGnt, .engGnt,
    .busReq, .romValid, .romAddr, .romData, .isoEvents, .asyncEvents, .intReq, .pmeReq,
    .card_status_change, .powerState, .cardMode);
  phsg_host_model host (.ref_clk, .rstn, .busReq, .lag, .busGnt, .masterDone);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // interrupt only when a masked-in status bit is set and power is full
  function automatic logic exp_int(logic [7:0] s, logic [7:0] m, logic [1:0] ps);
    return |(s & m) && ps == `PHSG_D0;
  endfunction
  task tally_and_finish;
    if (error_cnt == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait; running out is a mismatch and ends the run
  task automatic wt(ref logic s, input logic val, input int n);
    for (int i = 0; i < n && s !== val; i++) @(negedge ref_clk);
    if (s !== val)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  // one strobe cycle, then the acknowledge at its fixed latency
  task acc(logic m, logic w, logic [11:0] a, logic [31:0] d);
    @(negedge ref_clk);
    {memSel, cfgSel, memWr, cfgWr} = {m, !m, w, w};
    {memAddr, cfgAddr, memWdata, cfgWdata} = {a, a[7:0], d, d};
    @(negedge ref_clk);
    {memSel, cfgSel} = 0;
    if (m) wt(memAck, 1, 2);
    else wt(cfgAck, 1, 1);
    rd = m ? memRdata : cfgRdata;
  endtask
  task rst(logic s);
    rstn = 0;
    card_mode_select_n = s;
    repeat (6) @(negedge ref_clk);
    rstn = 1;
    repeat (4) @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    rst(1);
    chk({cardMode, powerState, busReq, intReq, pmeReq, engGnt}, 0);
    // clock enable low must freeze the arbiter although an engine asks
    clkEn = 0;
    engReq = 1;
    repeat (4) @(negedge ref_clk);
    chk(busReq, 0);
    engReq = 0;
    clkEn = 1;
    for (int s = 3; s >= 0; s--)
    begin
      acc(0, 1, `PHSG_CFG_PMCSR, s);
      acc(0, 0, `PHSG_CFG_PMCSR, 0);
      chk({rd[1:0], powerState}, {s[1:0], s[1:0]});
    end
    acc(0, 0, `PHSG_CFG_CIS, 0);
    chk(rd, 0);
    for (int u = 0; u < 2; u++)
    begin
      v = xs();
      ev = 8'h1 << v[10:8];
      acc(1, 1, {u[0], 11'h4}, v[7:0]);
      acc(1, 0, {u[0], 11'h4}, 0);
      chk(rd, v[7:0]);
      @(negedge ref_clk);
      {asyncEvents, isoEvents} = u ? {ev, 8'h0} : {8'h0, ev};
      @(negedge ref_clk);
      {asyncEvents, isoEvents} = 0;
      acc(1, 0, {u[0], 11'h0}, 0);
      chk(rd, ev);
      acc(0, 1, `PHSG_CFG_PMCSR, `PHSG_D2);
      repeat (4) @(negedge ref_clk);
      chk(intReq, 0);
      acc(0, 1, `PHSG_CFG_PMCSR, `PHSG_D0);
      repeat (3) @(negedge ref_clk);
      chk(intReq, exp_int(ev, v[7:0], `PHSG_D0));
      acc(1, 1, {u[0], 11'h0}, ev);
      acc(1, 0, {u[0], 11'h8}, 0);
      chk({rd[30:0], intReq}, 0);
    end
    // first round single requester so the yield order is known afterwards
    prev = 0;
    for (int r = 0; r < 8; r++)
    begin
      v = xs();
      lag = v[2:0];
      engReq = (r == 0 || v[4:3] == 0) ? 2'h1 : v[4:3];
      wt(busReq, 1, 3);
      chk(engGnt, engReq == 3 ? prev ^ 2'h3 : engReq);
      prev = engGnt;
      wt(busReq, 0, 40);
      engReq = 0;
      @(negedge ref_clk);
    end
    acc(0, 1, `PHSG_CFG_PMCSR, 32'h100 | `PHSG_D3HOT);
    {wakeEvent, d3Cold} = 2'h3;
    repeat (6) @(negedge ref_clk);
    chk(pmeReq, 0);
    auxPower = 1;
    wt(pmeReq, 1, 6);
    {wakeEvent, d3Cold} = 0;
    // let the synchronised wake drain, else its set beats the clear
    repeat (2) @(negedge ref_clk);
    acc(0, 1, `PHSG_CFG_PMCSR, 32'h8100);
    repeat (3) @(negedge ref_clk);
    chk(pmeReq, 0);
    rst(0);
    chk(cardMode, 1);
    acc(0, 0, `PHSG_CFG_CIS, 0);
    chk(rd, 32'h80);
    acc(0, 0, `PHSG_CFG_BAR1, 0);
    chk(rd, 0);
    v = xs();
    @(negedge ref_clk);
    {romValid, romAddr, romData} = {1'b1, v[4:0], v};
    @(negedge ref_clk);
    romValid = 0;
    acc(0, 0, `PHSG_CFG_TUPLE + 4 * v[4:0], 0);
    chk(rd, v);
    acc(0, 1, `PHSG_CFG_PMCSR, 32'h100);
    wakeEvent = 1;
    wt(card_status_change, 1, 6);
    chk(card_status_change, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
